// File: fanout_pkg.sv
// Constants shared by the dual-source clock fanout gate.
// Assumes all pins except the asynchronous reset_n are sampled as synchronous levels on the system clock.
package fanout_pkg;
  localparam int unsigned OUT_PAIRS = 5;
  localparam logic SRC_PRIMARY = 1'b1;
  localparam logic SRC_SECONDARY = 1'b0;
  localparam logic GATE_OPEN = 1'b0;
  localparam logic LEVEL_LVDS = 1'b0;
  localparam logic LEVEL_LVPECL = 1'b1;
  localparam logic RESET_GATED = 1'b1;
  typedef enum logic {level_lvds, level_lvpecl} level_t;
endpackage

// File: fanout_gate_sync.sv
// Gate synchroniser: latches the enable level on a falling source edge.
// Assumes the selected clock level is sampled on clk.
`timescale 1ns/100ps
module fanout_gate_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic src_level,
  input wire logic output_gate_n,
  output logic gated,
  output logic fall_edge
);
  logic src_prev;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end

  assign fall_edge = src_prev & ~src_level;

  // Gate changes only on a falling edge so no output pulse is shortened.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gated <= fanout_pkg::RESET_GATED;
    end else if (fall_edge) begin
      gated <= output_gate_n; // R5
    end
  end
endmodule

// File: fanout_buffer.sv
// Dual-source clock fanout with a synchronised output gate.
// Assumes clock inputs are slow enough to be sampled on clk.
// Assumes the controller changes the source choice only while gated.
// The outputs lag the chosen input by one clk cycle.
// Behaviour
// R1: source choice high routes primary pair.
// R2: source choice low routes secondary pair.
// R3: gate low lets outputs follow clock.
// R4: gate high forces true low, complement high.
// R5: gate change applies after falling source edge.
// R6: enabled outputs are non-inverting copies.
// R7: five identical pairs from one source.
// R8: level select low LVDS, high LVPECL.
// R9: controller switches source only while gated.
`timescale 1ns/100ps
module fanout_buffer #(
  parameter int unsigned PAIRS = fanout_pkg::OUT_PAIRS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic primary_in,
  input wire logic primary_in_comp,
  input wire logic secondary_in,
  input wire logic secondary_in_comp,
  input wire logic source_choice,
  input wire logic output_gate_n,
  input wire logic level_select,
  output logic [PAIRS-1:0] fanout_true,
  output logic [PAIRS-1:0] fanout_comp,
  output fanout_pkg::level_t out_level
);
  logic prim_level;
  logic sec_level;
  logic sel_true;
  logic gated;
  logic fall_edge;

  // A pair reads high only with the true leg high and the complement low;
  // equal legs read low, so a broken pair cannot toggle the loads.
  function automatic logic pair_level(input logic leg_true,
    input logic leg_comp);
    return leg_true & ~leg_comp;
  endfunction

  // Low on the pin, its undriven level, selects the LVDS standard.
  function automatic fanout_pkg::level_t level_of(input logic pin);
    return (pin == fanout_pkg::LEVEL_LVDS) ? fanout_pkg::level_lvds :
      fanout_pkg::level_lvpecl;
  endfunction

  // The source mux is not glitch-free; the controller swaps while gated.
  always_comb begin
    prim_level = pair_level(primary_in, primary_in_comp);
    sec_level = pair_level(secondary_in, secondary_in_comp);
    if (source_choice == fanout_pkg::SRC_PRIMARY) begin
      sel_true = prim_level; // R1
    end else begin
      sel_true = sec_level; // R2
    end
  end

  fanout_gate_sync fanout_gate_sync_i (
    .clk(clk),
    .reset_n(reset_n),
    .src_level(sel_true),
    .output_gate_n(output_gate_n),
    .gated(gated),
    .fall_edge(fall_edge)
  );

  // True legs: forced low while gated, else a copy of the chosen input.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fanout_true <= '0;
    end else if (gated != fanout_pkg::GATE_OPEN) begin
      fanout_true <= '0; // R4
    end else begin
      fanout_true <= {PAIRS{sel_true}}; // R3 R6 R7
    end
  end

  // Complement legs sit high while gated, the idle level of a stopped pair.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fanout_comp <= '1;
    end else if (gated != fanout_pkg::GATE_OPEN) begin
      fanout_comp <= '1; // R4
    end else begin
      fanout_comp <= {PAIRS{~sel_true}}; // R6 R7
    end
  end

  // A static pin, registered only so that out_level leaves a flip-flop.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_level <= fanout_pkg::level_lvds;
    end else begin
      out_level <= level_of(level_select); // R8
    end
  end

  property p_gated_low;
    @(posedge clk) disable iff (!reset_n)
      gated |=> (fanout_true == '0 && fanout_comp == '1);
  endproperty
  a_gated_low: assert property (p_gated_low) // R4
    else $error("gated out wrong");

  property p_follow;
    @(posedge clk) disable iff (!reset_n)
      !gated |=> fanout_true == {PAIRS{$past(sel_true)}};
  endproperty
  a_follow: assert property (p_follow) else $error("not following"); // R3

  property p_prim;
    @(posedge clk) disable iff (!reset_n)
      (!gated && source_choice) |=> fanout_true[0] == $past(prim_level);
  endproperty
  a_prim: assert property (p_prim) else $error("primary not routed"); // R1

  property p_sec;
    @(posedge clk) disable iff (!reset_n)
      (!gated && !source_choice) |=> fanout_true[0] == $past(sec_level);
  endproperty
  a_sec: assert property (p_sec) else $error("secondary not routed"); // R2

  property p_sync;
    @(posedge clk) disable iff (!reset_n)
      !fall_edge |=> $stable(gated);
  endproperty
  a_sync: assert property (p_sync) else $error("gate moved off edge"); // R5

  property p_take;
    @(posedge clk) disable iff (!reset_n)
      fall_edge |=> gated == $past(output_gate_n);
  endproperty
  a_take: assert property (p_take) else $error("gate not taken"); // R5

  property p_diff;
    @(posedge clk) disable iff (!reset_n)
      fanout_comp == ~fanout_true;
  endproperty
  a_diff: assert property (p_diff) else $error("pair not complementary"); // R6

  property p_same;
    @(posedge clk) disable iff (!reset_n)
      fanout_true == {PAIRS{fanout_true[0]}};
  endproperty
  a_same: assert property (p_same) else $error("pairs differ"); // R7

  property p_level;
    @(posedge clk) disable iff (!reset_n)
      1'b1 |=> out_level ==
        (($past(level_select) == fanout_pkg::LEVEL_LVPECL) ?
        fanout_pkg::level_lvpecl : fanout_pkg::level_lvds);
  endproperty
  a_level: assert property (p_level) else $error("level wrong"); // R8

  // One check per row of the pair truth table.
  property p_true_high;
    @(posedge clk) disable iff (!reset_n)
      (!gated && sel_true) |=> (fanout_true == '1 && fanout_comp == '0);
  endproperty
  a_true_high: assert property (p_true_high) // R6
    else $error("high input not copied");

  property p_true_low;
    @(posedge clk) disable iff (!reset_n)
      (!gated && !sel_true) |=> (fanout_true == '0 && fanout_comp == '1);
  endproperty
  a_true_low: assert property (p_true_low) // R6
    else $error("low input not copied");

  property p_comp_follow;
    @(posedge clk) disable iff (!reset_n)
      !gated |=> fanout_comp == ~{PAIRS{$past(sel_true)}};
  endproperty
  a_comp_follow: assert property (p_comp_follow) // R3
    else $error("complement not following");

  property p_prim_comp;
    @(posedge clk) disable iff (!reset_n)
      (!gated && source_choice) |=> fanout_comp[0] == ~$past(prim_level);
  endproperty
  a_prim_comp: assert property (p_prim_comp) // R1
    else $error("primary complement not routed");

  // The gate may open or close only at an edge that sampled the pin.
  property p_open_edge;
    @(posedge clk) disable iff (!reset_n)
      $fell(gated) |-> ($past(fall_edge) && !$past(output_gate_n));
  endproperty
  a_open_edge: assert property (p_open_edge) // R5
    else $error("gate opened off edge");

  property p_close_edge;
    @(posedge clk) disable iff (!reset_n)
      $rose(gated) |-> ($past(fall_edge) && $past(output_gate_n));
  endproperty
  a_close_edge: assert property (p_close_edge) // R5
    else $error("gate closed off edge");

  // The first cycle after reset is skipped: out_level still holds its reset
  // value there, whatever the pin was.
  property p_level_hold;
    @(posedge clk) disable iff (!reset_n)
      ($stable(level_select) && $past(reset_n)) |=> $stable(out_level);
  endproperty
  a_level_hold: assert property (p_level_hold) // R8
    else $error("level moved on a static pin");

  // Covers mark that each source, both gate moves and the LVPECL level were seen.

  c_enable: cover property (@(posedge clk) disable iff (!reset_n)
    $fell(gated));
  c_disable: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(gated));
  c_prim_run: cover property (@(posedge clk) disable iff (!reset_n)
    !gated && source_choice && fall_edge);
  c_sec_run: cover property (@(posedge clk) disable iff (!reset_n)
    !gated && source_choice == fanout_pkg::SRC_SECONDARY && fall_edge);
  c_level_pecl: cover property (@(posedge clk) disable iff (!reset_n)
    out_level == fanout_pkg::level_lvpecl);
endmodule

// File: src_clock_model.sv
// Board clock sources feeding both input pairs of the buffer.
// Assumes clk is the bench clock; levels move on its falling edge.
`timescale 1ns/100ps
module src_clock_model (
  input wire logic clk,
  output logic primary_in,
  output logic primary_in_comp,
  output logic secondary_in,
  output logic secondary_in_comp
);
  logic [3:0] cnt = 4'h0;
  // Unequal rates, so routing the wrong source shows as a mismatch.
  always @(negedge clk) cnt <= cnt + 4'h1;
  assign primary_in = cnt[1];
  assign primary_in_comp = ~cnt[1];
  assign secondary_in = cnt[2];
  assign secondary_in_comp = ~cnt[2];
endmodule

// File: dual_source_clock_fanout_gate_test.sv
// Bench for the fanout buffer: routing, gating and level select.
// Assumes src_clock_model supplies both input clocks.
`timescale 1ns/100ps
module dual_source_clock_fanout_gate_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic source_choice = 1'b0;
  logic output_gate_n = 1'b1;
  logic level_select = 1'b0;
  logic p, pc, s, sc, prv = 1'b0, gm = 1'b0, ev = 1'b0;
  logic [4:0] ft, fc;
  fanout_pkg::level_t lvl;
  int bad_count = 0, cmp_count = 0, cycles = 0;
  wire sel = source_choice ? p : s;
  initial forever #20 clk = ~clk;
  src_clock_model src_clock_model_i (.clk(clk), .primary_in(p),
    .primary_in_comp(pc), .secondary_in(s), .secondary_in_comp(sc));
  fanout_buffer fanout_buffer_i (.clk(clk), .reset_n(reset_n),
    .primary_in(p), .primary_in_comp(pc), .secondary_in(s),
    .secondary_in_comp(sc), .source_choice(source_choice),
    .output_gate_n(output_gate_n), .level_select(level_select),
    .fanout_true(ft), .fanout_comp(fc), .out_level(lvl));
  // Reference: the gate may only move on a falling edge of the source.
  always @(posedge clk) begin
    if (!reset_n) begin
      prv <= 1'b0;
      gm <= 1'b0;
      ev <= 1'b0;
    end else begin
      ev <= gm & sel;
      if (prv && !sel) gm <= ~output_gate_n;
      prv <= sel;
    end
    cycles++;
    if (cycles == 1000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic watch(input int n);
    repeat (n) begin
      @(negedge clk);
      cmp_count++;
      if (ft !== {5{ev}} || fc !== ~{5{ev}}) begin
        bad_count++;
        $display("[FAIL] %0t outputs %b %b", $time, ft, fc);
      end
    end
  endtask
  task automatic t_primary;
    source_choice = 1'b1;
    watch(4);
    output_gate_n = 1'b0;
    watch(14);
  endtask
  task automatic t_gate_off;
    output_gate_n = 1'b1;
    watch(14);
  endtask
  task automatic t_secondary;
    source_choice = 1'b0;
    watch(3);
    output_gate_n = 1'b0;
    watch(22);
  endtask
  // Mid-run reset: outputs gated at once, gate reopens only on a fall.
  task automatic t_reset;
    reset_n = 1'b0;
    watch(2);
    reset_n = 1'b1;
    watch(12);
  endtask
  task automatic t_level(input logic v, input fanout_pkg::level_t e);
    level_select = v;
    repeat (2) @(negedge clk);
    cmp_count++;
    if (lvl !== e) begin
      bad_count++;
      $display("[FAIL] %0t level %b", $time, lvl);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    t_primary();
    t_gate_off();
    t_secondary();
    t_reset();
    t_level(1'b1, fanout_pkg::level_lvpecl);
    t_level(1'b0, fanout_pkg::level_lvds);
    conclude();
  end
endmodule
